//--- hw/rss_pkg.sv
// Purpose: constants and types for the rail strobe sequencer
// Assumes: 125 MHz sys_clk, register port is a plain byte-wide strobe port
// Notes:
// Function
// - Each rail has a two-bit power-up step field in rail_up_order.
// - Each rail has a two-bit power-down step field in rail_down_order.
// - Power-up step 1 follows power good rise by 3/6/9/12 ms.
// - Power-up step 1 to step 2 takes 3/6/9/12 ms.
// - Power-up step 2 to step 3 takes 3/6/9/12 ms.
// - Power-up step 3 to step 4 takes 3/6/9/12 ms.
// - Power-down starts on wake falling; step 1 after 3 or 6 ms.
// - Power-down step 1 to step 2 takes 6/12/24/48 ms, unscaled.
// - Power-down step 2 to step 3 takes 6/12/24/48 ms, unscaled.
// - Power-down step 3 to step 4 takes 6/12/24/48 ms, unscaled.
// - Down delays 2 to 4 scale by 1 or 16; delay 1 never.
`default_nettype none
package rss_pkg;
   localparam logic [7:0] RSS_OFS_UP_ORDER   = 8'h09;
   localparam logic [7:0] RSS_OFS_UP_DELAY   = 8'h0A;
   localparam logic [7:0] RSS_OFS_DOWN_ORDER = 8'h0B;
   localparam logic [7:0] RSS_OFS_DOWN_DELAY = 8'h0C;
   localparam logic [7:0] RSS_RST_UP_ORDER   = 8'hE4;
   localparam logic [7:0] RSS_RST_UP_DELAY   = 8'h55;
   localparam logic [7:0] RSS_RST_DOWN_ORDER = 8'h1E;
   localparam logic [7:0] RSS_RST_DOWN_DELAY = 8'hE0;
   // Rail field positions (low bit), same in both order registers
   localparam int RSS_POS_GATE_HIGH  = 6;
   localparam int RSS_POS_SOURCE_POS = 4;
   localparam int RSS_POS_GATE_LOW   = 2;
   localparam int RSS_POS_SOURCE_NEG = 0;
   localparam int RSS_POS_DOWN_FACTOR = 0;
   localparam int RSS_POS_DOWN_DLY1   = 1;
   localparam int RSS_CLK_HZ   = 125000000;
   localparam int RSS_TIME_BASE_MS = 1;
   localparam int RSS_MS_CYCLES = RSS_CLK_HZ / 1000 * RSS_TIME_BASE_MS;
   localparam int RSS_UP_STEP_MS   = 3;
   localparam int RSS_DOWN_STEP_MS = 6;
   localparam int RSS_FACTOR_HI    = 16;
   typedef struct packed {
      logic gate_high_rail;
      logic source_pos_rail;
      logic gate_low_rail;
      logic source_neg_rail;
   } rss_rails_t;
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rss_reg_req_t;
endpackage
`default_nettype wire

//--- hw/rss_top.sv
// Purpose: four-step power-up/power-down rail sequencer with its four registers
// Assumes: inputs synchronous to sys_clk; register reads are combinational on addr
// Notes: a new sequence aborts a running one; the rails track the programmed steps
`default_nettype none
module rss_top #(
   parameter int MS_CYCLES = rss_pkg::RSS_MS_CYCLES
) (
   // Clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   // Sequencing inputs
   input  wire logic                  negative_boost_power_good,
   input  wire logic                  wake_pin,
   // Register port
   input  wire rss_pkg::rss_reg_req_t reg_req,
   output logic [7:0]                 reg_rdata,
   // Rail enables, step strobes and busy flag
   output rss_pkg::rss_rails_t        rails,
   output logic [3:0]                 step_strobe,
   output logic                       seq_busy
);
   import rss_pkg::*;

   typedef enum logic [1:0] {RSS_IDLE, RSS_UP, RSS_DOWN} rss_state_t;

   logic [7:0]  up_order_r, up_delay_r, down_order_r, down_delay_r;
   logic        pg_d_r, wake_d_r;
   rss_state_t  state_r;
   logic [1:0]  step_r;
   logic [9:0]  ms_left_r;
   logic [31:0] div_r;
   logic        ms_tick;
   logic        pg_rise, wake_fall;
   logic        down_phase_r;
   logic [4:0]  quiet_cnt_r;

   // Register writes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         up_order_r   <= RSS_RST_UP_ORDER;
         up_delay_r   <= RSS_RST_UP_DELAY;
         down_order_r <= RSS_RST_DOWN_ORDER;
         down_delay_r <= RSS_RST_DOWN_DELAY;
      end else if (reg_req.wr) begin
         if (reg_req.addr == RSS_OFS_UP_ORDER) begin
            up_order_r <= reg_req.wdata;
         end
         if (reg_req.addr == RSS_OFS_UP_DELAY) begin
            up_delay_r <= reg_req.wdata;
         end
         if (reg_req.addr == RSS_OFS_DOWN_ORDER) begin
            down_order_r <= reg_req.wdata;
         end
         if (reg_req.addr == RSS_OFS_DOWN_DELAY) begin
            down_delay_r <= reg_req.wdata;
         end
      end
   end

   always_comb begin
      unique case (reg_req.addr)
         RSS_OFS_UP_ORDER:   reg_rdata = up_order_r;
         RSS_OFS_UP_DELAY:   reg_rdata = up_delay_r;
         RSS_OFS_DOWN_ORDER: reg_rdata = down_order_r;
         RSS_OFS_DOWN_DELAY: reg_rdata = down_delay_r;
         default:            reg_rdata = 8'h00;
      endcase
   end

   // Delay in ms for the wait before step idx (0 = before step 1)
   function automatic logic [9:0] delay_ms(input logic down, input logic [1:0] idx);
      logic [1:0] code;
      logic [9:0] base;
      code = 2'b00;
      base = 10'h000;
      if (!down) begin
         code = up_delay_r[2*idx +: 2];
         base = 10'(RSS_UP_STEP_MS * (int'(code) + 1));
      end else if (idx == 2'd0) begin
         base = down_delay_r[RSS_POS_DOWN_DLY1] ? 10'(2 * RSS_UP_STEP_MS) : 10'(RSS_UP_STEP_MS);
      end else begin
         code = down_delay_r[2*idx +: 2];
         base = 10'(RSS_DOWN_STEP_MS) << code;
         if (down_delay_r[RSS_POS_DOWN_FACTOR]) begin
            base = 10'(int'(base) * RSS_FACTOR_HI);
         end
      end
      return base;
   endfunction

   assign pg_rise   = negative_boost_power_good && !pg_d_r;
   assign wake_fall = !wake_pin && wake_d_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pg_d_r   <= 1'b0;
         wake_d_r <= 1'b0;
      end else begin
         pg_d_r   <= negative_boost_power_good;
         wake_d_r <= wake_pin;
      end
   end

   // Millisecond time base, restarted with every sequence
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= 32'h0000_0000;
      end else if (pg_rise || wake_fall || state_r == RSS_IDLE || ms_tick) begin
         div_r <= 32'h0000_0000;
      end else begin
         div_r <= div_r + 32'h0000_0001;
      end
   end
   assign ms_tick = (state_r != RSS_IDLE) && (div_r == 32'(MS_CYCLES - 1));

   // Sequencer; wake fall wins over a power good rise in the same cycle; a later rise aborts the power-down
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r     <= RSS_IDLE;
         step_r      <= 2'd0;
         ms_left_r   <= 10'h000;
         step_strobe <= 4'h0;
      end else begin
         step_strobe <= 4'h0;
         if (wake_fall) begin
            state_r   <= RSS_DOWN;
            step_r    <= 2'd0;
            ms_left_r <= delay_ms(1'b1, 2'd0);
         end else if (pg_rise) begin
            state_r   <= RSS_UP;
            step_r    <= 2'd0;
            ms_left_r <= delay_ms(1'b0, 2'd0);
         end else if (state_r != RSS_IDLE && ms_tick) begin
            if (ms_left_r == 10'h001) begin
               step_strobe[step_r] <= 1'b1;
               if (step_r == 2'd3) begin
                  state_r <= RSS_IDLE;
               end else begin
                  step_r    <= step_r + 2'd1;
                  ms_left_r <= delay_ms(state_r == RSS_DOWN, step_r + 2'd1);
               end
            end else begin
               ms_left_r <= ms_left_r - 10'h001;
            end
         end
      end
   end
   assign seq_busy = (state_r != RSS_IDLE);

   // Rail enables, all rails of one step switch in the same cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rails <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (step_strobe[i]) begin
               if (up_order_r[RSS_POS_GATE_HIGH +: 2] == 2'(i) && !down_phase_r) rails.gate_high_rail <= 1'b1;
               if (up_order_r[RSS_POS_SOURCE_POS +: 2] == 2'(i) && !down_phase_r) rails.source_pos_rail <= 1'b1;
               if (up_order_r[RSS_POS_GATE_LOW +: 2] == 2'(i) && !down_phase_r) rails.gate_low_rail <= 1'b1;
               if (up_order_r[RSS_POS_SOURCE_NEG +: 2] == 2'(i) && !down_phase_r) rails.source_neg_rail <= 1'b1;
               if (down_order_r[RSS_POS_GATE_HIGH +: 2] == 2'(i) && down_phase_r) rails.gate_high_rail <= 1'b0;
               if (down_order_r[RSS_POS_SOURCE_POS +: 2] == 2'(i) && down_phase_r) rails.source_pos_rail <= 1'b0;
               if (down_order_r[RSS_POS_GATE_LOW +: 2] == 2'(i) && down_phase_r) rails.gate_low_rail <= 1'b0;
               if (down_order_r[RSS_POS_SOURCE_NEG +: 2] == 2'(i) && down_phase_r) rails.source_neg_rail <= 1'b0;
            end
         end
      end
   end

   // Direction of the strobes just issued; held after the last step ends the sequence
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         down_phase_r <= 1'b0;
      end else if (wake_fall) begin
         down_phase_r <= 1'b1;
      end else if (pg_rise) begin
         down_phase_r <= 1'b0;
      end
   end

   // Strobe-free cycles, saturating; a long quiet stretch is checked here, not by a long repetition
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         quiet_cnt_r <= 5'h00;
      end else if (step_strobe != 4'h0) begin
         quiet_cnt_r <= 5'h00;
      end else if (quiet_cnt_r != 5'h1F) begin
         quiet_cnt_r <= quiet_cnt_r + 5'h01;
      end
   end

   sequence s_up_start;
      pg_rise && !wake_fall && up_delay_r[1:0] == 2'b00 && MS_CYCLES == 4;
   endsequence

   sequence s_first_strobe;
      ##13 (step_strobe == 4'h1 && quiet_cnt_r >= 5'd13);
   endsequence

   property p_up_first;
      @(posedge sys_clk) disable iff (!rst_n)
      s_up_start |-> s_first_strobe;
   endproperty
   a_up_first: assert property (p_up_first) else $error("up step 1 timing wrong");

   property p_ascend;
      @(posedge sys_clk) disable iff (!rst_n)
      step_strobe[1] |-> $past(step_r) == 2'd1;
   endproperty
   a_ascend: assert property (p_ascend) else $error("steps out of order");

   property p_onehot;
      @(posedge sys_clk) disable iff (!rst_n)
      $onehot0(step_strobe);
   endproperty
   a_onehot: assert property (p_onehot) else $error("two steps at once");

   property p_gh_up;
      @(posedge sys_clk) disable iff (!rst_n)
      (step_strobe[up_order_r[RSS_POS_GATE_HIGH +: 2]] && !down_phase_r && $stable(up_order_r)) |=>
         rails.gate_high_rail;
   endproperty
   a_gh_up: assert property (p_gh_up) else $error("gate high rail missed its step");

   property p_sn_down;
      @(posedge sys_clk) disable iff (!rst_n)
      (step_strobe[down_order_r[RSS_POS_SOURCE_NEG +: 2]] && down_phase_r && !wake_fall && !pg_rise) |=>
         !rails.source_neg_rail;
   endproperty
   a_sn_down: assert property (p_sn_down) else $error("source neg rail missed its step");

   property p_dn_first;
      @(posedge sys_clk) disable iff (!rst_n)
      (wake_fall && !down_delay_r[RSS_POS_DOWN_DLY1] && MS_CYCLES == 4) |->
         ##1 (ms_left_r == 10'd3);
   endproperty
   a_dn_first: assert property (p_dn_first) else $error("down delay 1 wrong");

   property p_dn_scale;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_r == RSS_DOWN && ms_tick && ms_left_r == 10'h001 && step_r == 2'd0 && !wake_fall && !pg_rise) |=>
         ms_left_r == ((10'(RSS_DOWN_STEP_MS) << down_delay_r[3:2]) * (down_delay_r[0] ? 10'd16 : 10'd1));
   endproperty
   a_dn_scale: assert property (p_dn_scale) else $error("down delay 2 wrong");

   property p_up_next;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_r == RSS_UP && ms_tick && ms_left_r == 10'h001 && step_r == 2'd1 && !wake_fall && !pg_rise) |=>
         ms_left_r == 10'(RSS_UP_STEP_MS * (int'(up_delay_r[5:4]) + 1));
   endproperty
   a_up_next: assert property (p_up_next) else $error("up delay 3 wrong");

endmodule
`default_nettype wire

//--- bench/rss_top_tb.sv
// Purpose: self-checking bench for the rail strobe sequencer
// Assumes: MS_CYCLES shortened to 4; strobe lands delay*MS_CYCLES cycles after its cause
// Notes: random register settings come from a bench LFSR; rails and strobes checked every cycle of each sequence
`default_nettype none
module rss_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rss_pkg::*;
   localparam int MS = 4;
   logic          sys_clk;
   logic          rst_n;
   logic          negative_boost_power_good;
   logic          wake_pin;
   rss_reg_req_t  reg_req;
   logic [7:0]    reg_rdata;
   rss_rails_t    rails;
   logic [3:0]    step_strobe;
   logic          seq_busy;
   logic [7:0]    m_reg [4];
   logic [3:0]    exp_rails;
   logic [31:0]   lfsr;
   int            errors;
   int            compares;

   rss_top #(.MS_CYCLES(MS)) dut (
      .sys_clk                   (sys_clk),
      .rst_n                     (rst_n),
      .negative_boost_power_good (negative_boost_power_good),
      .wake_pin                  (wake_pin),
      .reg_req                   (reg_req),
      .reg_rdata                 (reg_rdata),
      .rails                     (rails),
      .step_strobe               (step_strobe),
      .seq_busy                  (seq_busy)
   );

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic chk_val(input string what, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chk_time(input string what, input int e, input int g);
      compares++;
      if (g != e) begin
         errors++;
         $display("unexpected %s expected %0d seen %0d", what, e, g);
      end
   endtask

   task automatic tally_and_finish();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_req = '{1'b1, a, d};
      @(negedge sys_clk);
      reg_req.wr = 1'b0;
      if (a >= RSS_OFS_UP_ORDER && a <= RSS_OFS_DOWN_DELAY) m_reg[a - RSS_OFS_UP_ORDER] = d;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      reg_req.addr = a;
      #1;
      chk_val("register read", e, reg_rdata);
   endtask

   // Runs one whole sequence and tracks every strobe and rail against the model
   task automatic run_seq(input bit up);
      int         t;
      int         d;
      logic [7:0] ord;
      logic [7:0] dly;
      logic [3:0] nxt;
      ord = up ? m_reg[0] : m_reg[2];
      dly = up ? m_reg[1] : m_reg[3];
      nxt = exp_rails;
      @(negedge sys_clk);
      if (up) negative_boost_power_good = 1'b1;
      else wake_pin = 1'b0;
      for (int k = 0; k < 4; k++) begin
         if (up) d = 3 * (int'(dly[2*k +: 2]) + 1);
         else if (k == 0) d = dly[1] ? 6 : 3;
         else d = (6 << dly[2*k +: 2]) * (dly[0] ? 16 : 1);
         t = (k == 0) ? -1 : 0;
         do begin
            @(posedge sys_clk);
            #1;
            t++;
            exp_rails = nxt;
            chk_val("rails", {4'h0, exp_rails}, {4'h0, rails});
         end while (step_strobe === 4'h0 && t < d * MS + 9);
         chk_val("step strobe", 8'(4'h1 << k), {4'h0, step_strobe});
         chk_time("step interval", d * MS, t);
         if (k < 3) chk_val("busy", 8'h01, {7'h0, seq_busy});
         for (int i = 0; i < 4; i++) begin
            if (ord[2*i +: 2] == k[1:0]) nxt[i] = up;
         end
      end
      repeat (2) begin
         @(posedge sys_clk);
         #1;
         exp_rails = nxt;
         chk_val("rails", {4'h0, exp_rails}, {4'h0, rails});
      end
      chk_val("busy", 8'h00, {7'h0, seq_busy});
      @(negedge sys_clk);
      negative_boost_power_good = 1'b0;
      wake_pin = 1'b1;
      repeat (3) @(negedge sys_clk);
   endtask

   initial begin
      #(8ns * 60000);
      errors++;
      $display("unexpected watchdog expected done seen hang");
      tally_and_finish();
   end

   initial begin
      errors = 0;
      compares = 0;
      lfsr = 32'h3264;
      exp_rails = 4'h0;
      rst_n = 1'b0;
      negative_boost_power_good = 1'b0;
      wake_pin = 1'b1;
      reg_req = '{1'b0, 8'h00, 8'h00};
      m_reg = '{RSS_RST_UP_ORDER, RSS_RST_UP_DELAY, RSS_RST_DOWN_ORDER, RSS_RST_DOWN_DELAY};
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_n = 1'b1;
      for (int a = 9; a <= 12; a++) rd_chk(8'(a), m_reg[a - 9]);
      wr_reg(8'h0D, 8'hFF);
      rd_chk(8'h0D, 8'h00);
      rd_chk(RSS_OFS_UP_ORDER, RSS_RST_UP_ORDER);
      for (int n = 0; n < 4; n++) begin
         if (n > 0) begin
            for (int a = 9; a <= 12; a++) begin
               lfsr = lfsr_next(lfsr);
               wr_reg(8'(a), (a == 10 && n == 1) ? (lfsr[7:0] & 8'hFC) : lfsr[7:0]);
            end
            for (int a = 9; a <= 12; a++) rd_chk(8'(a), m_reg[a - 9]);
         end
         run_seq(1'b1);
         run_seq(1'b0);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
